// ==== dv/cedu_pipe_model.sv ====
/*
  Pipeline model: presents one retiring instruction record a
  cycle after each request and keeps a float fault raised.
  Assumes requests change just after rising edges of clk.
*/
`default_nettype none

module cedu_pipe_model
  import cedu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        go,
  input  wire cedu_instr_t req,
  input  wire logic        fp_clr,
  output cedu_instr_t      instr
);
  timeunit 1ns;
  timeprecision 1ps;

  logic fp_hold = 1'b0;

  // ==========================================================
  // float unit
  // fault stays up until the handler clears the float status
  always_ff @(posedge clk) begin
    if (fp_clr) begin
      fp_hold <= 1'b0;
    end else if (go && req.fp_exc) begin
      fp_hold <= 1'b1;
    end
  end

  // idle cycles show the inverse, so stale records never pass
  always_ff @(posedge clk) begin
    if (go) begin
      instr        <= req;
      instr.fp_exc <= req.fp_exc | fp_hold;
    end else begin
      instr       <= ~req;
      instr.valid <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ==== dv/cpu_exception_detect_unit_test.sv ====
/*
  Self-checking bench of the exception detect unit: register
  accesses, instruction records and interrupt lines.
  Assumes cedu_pkg and the pipeline model compiled first.
*/
`default_nettype none

module cpu_exception_detect_unit_test;
  import cedu_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk     = 1'b0;
  logic        rst_b       = 1'b0;
  logic [3:0]  addr        = 4'h0;
  logic [31:0] wdata       = 32'h0;
  logic        wr          = 1'b0;
  logic        rd          = 1'b0;
  logic [4:0]  irq         = 5'h00;
  logic [1:0]  perf        = 2'h0;
  logic        go          = 1'b0;
  logic        fp_clr      = 1'b0;
  logic [31:0] base        = 32'h0;
  logic [31:0] rdata;
  logic        keep;
  logic        fill;
  logic        kp;
  logic        fl;
  cedu_instr_t req         = '0;
  cedu_instr_t r           = '0;
  cedu_instr_t instr;
  cedu_exc_t   exc;
  int          n_errors    = 0;
  int          check_count = 0;
  logic [31:0] ri_w [3]    = '{32'h7000_0000, 32'h0000_0005,
                               32'h0404_0000};

  always #2 sys_clk = ~sys_clk;

  cedu_unit i_dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .INSTR(instr), .IRQ_EXT(irq), .PERF_EVENT(perf), .EXC(exc),
    .CACHE_KEEP(keep), .FILL_GO(fill));

  cedu_pipe_model i_pipe (.clk(sys_clk), .go(go), .req(req),
    .fp_clr(fp_clr), .instr(instr));

  // ==========================================================
  // checking and closing
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    wrap_up();
  end

  // ==========================================================
  // register bus and instruction tasks
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  // read data appear in the cycle after the strobe and hold until the next read
  task automatic rreg(input logic [3:0] a, input logic [31:0] m,
                      input logic [31:0] exp, input string nm);
    @(posedge sys_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 chk(nm, rdata & m, exp);
  endtask

  // exception answer is a one-cycle pulse after the record
  task automatic xact(input logic tk, input logic [4:0] cd);
    @(posedge sys_clk);
    go  <= 1'b1;
    req <= r;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    #1;
    kp = keep;
    fl = fill;
    chk("take", exc.take, tk);
    if (tk) begin
      chk("code", exc.code, cd);
      chk("epc", exc.pc, r.delay_slot ? r.branch_pc : r.pc);
      chk("bd", exc.bd, r.delay_slot);
      if (cd == 5'h0B) chk("unit", exc.ce, r.word[27:26]);
      wreg(4'h0, base);
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    r.valid     = 1'b1;
    r.word      = 32'h0000_0020;
    r.pc        = 32'h0000_0100;
    r.branch_pc = 32'h0000_00FC;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rreg(4'h0, 32'hFFFF_FFFF, 32'h0000_0004, "status");
    rreg(4'h1, 32'h0000_8000, 32'h0000_8000, "ip7");
    wreg(4'h6, 32'hFFFF_0000);
    rreg(4'h1, 32'h0000_FF00, 32'h0, "ip");
    wreg(4'h0, base);
    // undefined encodings, odd ones in a delay slot
    foreach (ri_w[i]) begin
      r.word       = ri_w[i];
      r.delay_slot = i[0];
      xact(1'b1, 5'h0A);
    end
    r.word       = 32'h0000_0020;
    r.delay_slot = 1'b0;
    r.op64       = 1'b1;
    xact(1'b0, 5'h00);
    base = 32'h0000_0010;
    wreg(4'h0, base);
    xact(1'b1, 5'h0A);
    r.op64 = 1'b0;
    r.word = 32'h4000_0000;
    xact(1'b1, 5'h0B);
    base = 32'h0;
    wreg(4'h0, base);
    for (int u = 0; u < 3; u++) begin
      r.word = {4'h4, u[1:0], 26'h0};
      xact(u != 0, 5'h0B);
    end
    base   = 32'h2000_0000;
    r.word = 32'h4C00_0000;
    wreg(4'h0, base);
    xact(1'b1, 5'h0A);
    base = 32'h2100_0000;
    wreg(4'h0, base);
    xact(1'b0, 5'h00);
    // float fault behind a reserved op, then cleared
    r.word   = 32'h7000_0000;
    r.fp_exc = 1'b1;
    xact(1'b1, 5'h0A);
    r.word   = 32'h0000_0020;
    r.fp_exc = 1'b0;
    xact(1'b1, 5'h0F);
    fp_clr <= 1'b1;
    @(posedge sys_clk);
    fp_clr <= 1'b0;
    xact(1'b0, 5'h00);
    // watch hits, immediate and deferred
    wreg(4'h4, 32'h0000_0012);
    wreg(4'h3, 32'h0000_1003);
    r.paddr   = 40'h12_0000_1000;
    r.is_load = 1'b1;
    xact(1'b1, 5'h17);
    chk("cache", {fl, kp}, 32'h1);
    r.cacheable = 1'b1;
    r.dc_miss   = 1'b1;
    xact(1'b1, 5'h17);
    chk("cache", {fl, kp}, 32'h2);
    r.is_cache = 1'b1;
    xact(1'b0, 5'h00);
    r.is_cache = 1'b0;
    r.is_load  = 1'b0;
    r.is_store = 1'b1;
    wreg(4'h3, 32'h0000_1002);
    xact(1'b0, 5'h00);
    wreg(4'h3, 32'h0000_1003);
    wreg(4'h0, base | 32'h2);
    xact(1'b0, 5'h00);
    wreg(4'h0, base);
    r.is_store = 1'b0;
    r.pc       = 32'h0000_0200;
    xact(1'b1, 5'h17);
    wreg(4'h0, base | 32'h4);
    r.is_store = 1'b1;
    xact(1'b0, 5'h00);
    wreg(4'h3, 32'h0);
    wreg(4'h0, base);
    r.is_store = 1'b0;
    xact(1'b0, 5'h00);
    // software, masked, external and counter requests
    wreg(4'h1, 32'h0000_0100);
    rreg(4'h1, 32'h0000_FF00, 32'h0000_0100, "ip");
    base = 32'h0000_0101;
    wreg(4'h0, base);
    xact(1'b1, 5'h00);
    wreg(4'h1, 32'h0);
    rreg(4'h1, 32'h0000_FF00, 32'h0, "ip");
    xact(1'b0, 5'h00);
    wreg(4'h1, 32'h0000_0200);
    xact(1'b0, 5'h00);
    base = 32'h0000_0200;
    wreg(4'h0, base);
    xact(1'b0, 5'h00);
    wreg(4'h1, 32'h0);
    irq <= 5'h01;
    repeat (3) @(posedge sys_clk);
    rreg(4'h1, 32'h0000_FF00, 32'h0000_0400, "ip");
    base = 32'h0000_0401;
    wreg(4'h0, base);
    xact(1'b1, 5'h00);
    irq  <= 5'h00;
    base = 32'h0;
    wreg(4'h0, base);
    perf <= 2'b10;
    wreg(4'h8, 32'h7FFF_FFFF);
    rreg(4'h1, 32'h0000_8000, 32'h0000_8000, "ip7");
    wreg(4'h8, 32'h0);
    rreg(4'h1, 32'h0000_8000, 32'h0, "ip7");
    // second reset with external lines busy
    irq <= 5'h1F;
    repeat (3) @(posedge sys_clk);
    irq   <= 5'h00;
    rst_b <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rreg(4'h1, 32'h0000_7C00, 32'h0, "ext");
    wrap_up();
  end
endmodule

`default_nettype wire

// ==== verilog/cedu_defines.svh ====
/*
  Constants of the exception detect unit: register map, field
  positions, reset values, opcode groups and cause codes.
  Assumes inclusion by bare name from the package; the unit sees the macros from there.
*/
`ifndef CEDU_DEFINES_SVH
`define CEDU_DEFINES_SVH

// ==========================================================
// register word addresses
`define CEDU_A_STATUS  4'h0
`define CEDU_A_CAUSE   4'h1
`define CEDU_A_EPC     4'h2
`define CEDU_A_WLO     4'h3
`define CEDU_A_WHI     4'h4
`define CEDU_A_COUNT   4'h5
`define CEDU_A_COMPARE 4'h6
`define CEDU_A_PERF0   4'h7
`define CEDU_A_PERF1   4'h8

// ==========================================================
// status fields, reset value and writable bits
`define CEDU_STATUS_RST 32'h0000_0004
`define CEDU_ST_WMASK   32'hF100_FFFF
`define CEDU_ST_IE  0
`define CEDU_ST_EXL 1
`define CEDU_ST_ERL 2
`define CEDU_ST_KSU 4:3
`define CEDU_ST_UX  5
`define CEDU_ST_SX  6
`define CEDU_ST_KX  7
`define CEDU_ST_IM  15:8
`define CEDU_ST_FX  24
`define CEDU_ST_CU  31:28
`define CEDU_KSU_KERN  2'h0
`define CEDU_KSU_SUPER 2'h1
`define CEDU_KSU_USER  2'h2

// ==========================================================
// cause, watch and counter fields
`define CEDU_CA_BD  31
`define CEDU_CA_CE  29:28
`define CEDU_CA_IP  15:8
`define CEDU_CA_SW  9:8
`define CEDU_CA_EXC 6:2
`define CEDU_WL_ADDR  31:3
`define CEDU_WL_LOAD  1
`define CEDU_WL_STORE 0
`define CEDU_WH_ADDR  7:0
`define CEDU_PA_LO    31:3
`define CEDU_PA_HI    39:32
`define CEDU_OVF      31
`define CEDU_IP_TIMER 7

// ==========================================================
// instruction fields and opcode groups
`define CEDU_OP 31:26
`define CEDU_FN 5:0
`define CEDU_RT 20:16
`define CEDU_OPC_SPECIAL 6'h00
`define CEDU_OPC_REG_IMMEDIATE_GROUP  6'h01
`define CEDU_OPC_FPX     6'h13
`define CEDU_COPZ_GRP    4'h4
`define CEDU_LSC_GRP     2'h3
`define CEDU_MAJOR_OK   64'hF7FF_FFFF_0FFF_FFFF
`define CEDU_SPECIAL_OK 64'hDD5F_FCFF_FFDF_BFDF
`define CEDU_REG_IMMEDIATE_GROUP_OK  32'h000F_5F0F

// ==========================================================
// exception codes
`define CEDU_EXC_INT   5'h00
`define CEDU_EXC_RI    5'h0A
`define CEDU_EXC_CPU   5'h0B
`define CEDU_EXC_FPE   5'h0F
`define CEDU_EXC_WATCH 5'h17

`endif

// ==== verilog/cedu_pkg.sv ====
/*
  Types of the exception detect unit: the retiring instruction
  record, the exception record and the watch deferral states.
  Assumes cedu_defines.svh on the include path.
*/
`default_nettype none

package cedu_pkg;
  `include "cedu_defines.svh"

  // ========================================================
  // one instruction at the retire point
  typedef struct packed {
    logic        valid;
    logic [31:0] word;
    logic [31:0] pc;
    logic [31:0] branch_pc;
    logic        delay_slot;
    logic        op64;
    logic        is_load;
    logic        is_store;
    logic        is_cache;
    logic        cacheable;
    logic        dc_miss;
    logic [39:0] paddr;
    logic        fp_exc;
  } cedu_instr_t;

  // exception taken, one cycle after its instruction
  typedef struct packed {
    logic        take;
    logic [4:0]  code;
    logic [31:0] pc;
    logic        bd;
    logic [1:0]  ce;
  } cedu_exc_t;

  typedef enum logic [1:0] {
    CEDU_W_IDLE = 2'b01,
    CEDU_W_PEND = 2'b10
  } cedu_wstate_t;
endpackage

`default_nettype wire

// ==== verilog/cedu_unit.sv ====
/*
  Exception detect unit: checks each retiring instruction for
  reserved, coprocessor, float, watch and interrupt exceptions
  and keeps status, cause, epc, watch and timer registers.
  Assumes the pipeline presents one instruction record per
  cycle on SYS_CLK and flushes when EXC.take is seen.
*/
// Added by the designer: the address-and-strobe port and the register addresses.
`default_nettype none

// Behaviour
// - undefined major opcode raises reserved-instruction exception.
// - undefined special function code raises reserved exception.
// - undefined reg-immediate sub-opcode raises reserved exception.
// - user/supervisor 32-bit addressing makes 64-bit ops reserved.
// - kernel mode always accepts 64-bit ops, whatever KX holds.
// - indexed float op without newer level enabled is reserved.
// - reserved exception records the reserved-operation code.
// - epc is instruction address, or branch address in slot.
// - unusable coprocessor 1/2, or 0 outside kernel, faults.
// - coprocessor fault records code and referenced unit.
// - float fault from coprocessor records float code, unmaskable.
// - load/store hitting watch address faults per enabled type.
// - watched cacheable miss still fills; else cache unchanged.
// - cache-maintenance instructions never raise a new watch; a pending one still goes out.
// - watch hit under exl/erl executes and waits pending.
// - pending watch dropped on reset or watch-low write.
// - eight masked interrupt lines, all gated by global enable.
// - pending field shows the live request lines.
// - bit 7 set on count equal compare or counter overflow.
// - compare write clears timer; zero overflow clears counter.
// - software clears soft requests writing zero; taken late.
// - reset clears external requests in bits 2 to 6.
// - delay-slot flag set beside the adjusted epc.
module cedu_unit
  import cedu_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_B,
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  input  wire cedu_instr_t INSTR,
  input  wire logic [4:0]  IRQ_EXT,
  input  wire logic [1:0]  PERF_EVENT,
  output cedu_exc_t        EXC,
  output logic             CACHE_KEEP,
  output logic             FILL_GO
);

  localparam logic [63:0] MAJOR_OK = `CEDU_MAJOR_OK;
  localparam logic [63:0] SPEC_OK  = `CEDU_SPECIAL_OK;
  localparam logic [31:0] RIMM_OK  = `CEDU_REG_IMMEDIATE_GROUP_OK;

  // ========================================================
  // reset release
  logic rst_meta;
  logic rst_sync_b;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta   <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  // ========================================================
  // external request lines, two flops from the pins
  logic [4:0] irq_meta;
  logic [4:0] irq_sync;

  always_ff @(posedge SYS_CLK or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      irq_meta <= 5'h00;
      irq_sync <= 5'h00;
    end else begin
      irq_meta <= IRQ_EXT;
      irq_sync <= irq_meta;
    end
  end

  // ========================================================
  // registers and write decode
  logic [31:0]  status;
  logic [31:0]  exception_return_pc;
  logic [31:0]  wlo;
  logic [31:0]  whi;
  logic [31:0]  count;
  logic [31:0]  compare;
  logic [31:0]  perf0;
  logic [31:0]  perf1;
  logic [4:0]   exc_code;
  logic         bd;
  logic [1:0]   ce;
  logic [1:0]   sw_ip;
  logic         timer_flag;
  cedu_wstate_t wstate;
  cedu_wstate_t next_wstate;

  logic wr_status;
  logic wr_cause;
  logic wr_wlo;
  logic wr_cmp;

  assign wr_status = REG_WR && REG_ADDR == `CEDU_A_STATUS;
  assign wr_cause  = REG_WR && REG_ADDR == `CEDU_A_CAUSE;
  assign wr_wlo    = REG_WR && REG_ADDR == `CEDU_A_WLO;
  assign wr_cmp    = REG_WR && REG_ADDR == `CEDU_A_COMPARE;

  // ========================================================
  // decode of the retiring instruction
  logic [5:0] op;
  logic       lvl;
  logic       kern;
  logic       addr32;
  logic       ri_major;
  logic       ri_spec;
  logic       ri_rimm;
  logic       ri_64;
  logic       ri_fx;
  logic       ri_hit;
  logic       cop_ref;
  logic [1:0] cop_unit;
  logic [3:0] cu_bits;
  logic       cpu_hit;
  logic       fpe_hit;
  logic       w_match;
  logic       watch_hit;
  logic       pend_go;
  logic [7:0] ip;
  logic       int_hit;

  assign op   = INSTR.word[`CEDU_OP];
  assign lvl  = status[`CEDU_ST_EXL] | status[`CEDU_ST_ERL];
  // exl/erl force kernel privilege, so KX plays no part here
  assign kern = status[`CEDU_ST_KSU] == `CEDU_KSU_KERN | lvl;
  assign addr32 =
    (status[`CEDU_ST_KSU] == `CEDU_KSU_USER & !status[`CEDU_ST_UX]) |
    (status[`CEDU_ST_KSU] == `CEDU_KSU_SUPER & !status[`CEDU_ST_SX]);

  // reserved-instruction sources
  assign ri_major = !MAJOR_OK[op];
  assign ri_spec  = op == `CEDU_OPC_SPECIAL &&
                    !SPEC_OK[INSTR.word[`CEDU_FN]];
  assign ri_rimm  = op == `CEDU_OPC_REG_IMMEDIATE_GROUP &&
                    !RIMM_OK[INSTR.word[`CEDU_RT]];
  assign ri_64    = INSTR.op64 & !kern & addr32;
  assign ri_fx    = op == `CEDU_OPC_FPX &&
                    !status[`CEDU_ST_FX];
  assign ri_hit   = INSTR.valid &
                    (ri_major | ri_spec | ri_rimm | ri_64 | ri_fx);

  // coprocessor reference: cop group or cop load/store
  always_comb begin
    cop_ref  = 1'b0;
    cop_unit = op[1:0];
    if (op[5:2] == `CEDU_COPZ_GRP) begin
      cop_ref = 1'b1;
      if (op == `CEDU_OPC_FPX) begin
        cop_unit = 2'h1;
      end
    end else if (op[5:4] == `CEDU_LSC_GRP) begin
      cop_ref = op[1:0] != 2'h0 && op[1:0] != 2'h3;
    end
  end

  // unit 0 needs no mark in kernel mode
  assign cu_bits = status[`CEDU_ST_CU];
  assign cpu_hit = INSTR.valid & cop_ref &
                   !cu_bits[cop_unit] &
                   !(cop_unit == 2'h0 & kern);
  assign fpe_hit = INSTR.valid & INSTR.fp_exc;

  // cache ops are excluded before any address compare
  assign w_match =
    INSTR.paddr[`CEDU_PA_LO] == wlo[`CEDU_WL_ADDR] &&
    INSTR.paddr[`CEDU_PA_HI] == whi[`CEDU_WH_ADDR];
  assign watch_hit = INSTR.valid & !INSTR.is_cache & w_match &
    ((INSTR.is_load & wlo[`CEDU_WL_LOAD]) |
     (INSTR.is_store & wlo[`CEDU_WL_STORE]));
  // deferred watch goes out on the first instruction with exl and erl clear
  assign pend_go = INSTR.valid & wstate == CEDU_W_PEND &
                   !lvl;

  // live pending field; bit 7 internal
  assign ip = {timer_flag | perf0[`CEDU_OVF] | perf1[`CEDU_OVF],
               irq_sync, sw_ip};
  // soft requests wait for the next retiring instruction
  assign int_hit = INSTR.valid & status[`CEDU_ST_IE] & !lvl &
                   |(ip & status[`CEDU_ST_IM]);

  // ========================================================
  // priority: one exception, one code
  logic       take;
  logic [4:0] code;
  logic       watch_now;
  logic       defer_set;
  logic [31:0] epc_src;

  always_comb begin
    take = 1'b1;
    code = `CEDU_EXC_INT;
    if (ri_hit) begin
      code = `CEDU_EXC_RI;
    end else if (cpu_hit) begin
      code = `CEDU_EXC_CPU;
    end else if (fpe_hit) begin
      code = `CEDU_EXC_FPE;
    end else if ((watch_hit & !lvl) | pend_go) begin
      code = `CEDU_EXC_WATCH;
    end else if (!int_hit) begin
      take = 1'b0;
    end
  end

  assign watch_now = watch_hit & !lvl & !ri_hit & !cpu_hit &
                     !fpe_hit;
  assign defer_set = watch_hit & lvl & !ri_hit & !cpu_hit &
                     !fpe_hit;
  assign epc_src = INSTR.delay_slot ? INSTR.branch_pc :
                   INSTR.pc;

  // ========================================================
  // watch deferral
  always_comb begin
    next_wstate = wstate;
    case (wstate)
      CEDU_W_IDLE: begin
        next_wstate = CEDU_W_IDLE;
      end
      CEDU_W_PEND: begin
        if (pend_go && code == `CEDU_EXC_WATCH) begin
          next_wstate = CEDU_W_IDLE;
        end
      end
      default: begin
        next_wstate = CEDU_W_IDLE;
      end
    endcase
    if (wr_wlo) begin
      next_wstate = CEDU_W_IDLE;
    end
    // a new deferral beats a same-cycle discard
    if (defer_set) begin
      next_wstate = CEDU_W_PEND;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wstate <= CEDU_W_IDLE;
    end else begin
      wstate <= next_wstate;
    end
  end

  // ========================================================
  // status: exception entry sets exl over a software write
  always_ff @(posedge SYS_CLK or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      status <= `CEDU_STATUS_RST;
    end else begin
      if (wr_status) begin
        status <= REG_WDATA & `CEDU_ST_WMASK;
      end
      if (take) begin
        status[`CEDU_ST_EXL] <= 1'b1;
      end
    end
  end

  // ========================================================
  // cause code, slot flag, unit and epc
  always_ff @(posedge SYS_CLK or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      exc_code <= `CEDU_EXC_INT;
      bd       <= 1'b0;
      ce       <= 2'h0;
      exception_return_pc      <= 32'h0000_0000;
    end else if (take) begin
      exc_code <= code;
      if (code == `CEDU_EXC_CPU) begin
        ce <= cop_unit;
      end
      // nested entry keeps the first return point
      if (!status[`CEDU_ST_EXL]) begin
        exception_return_pc <= epc_src;
        bd  <= INSTR.delay_slot;
      end
    end else if (REG_WR && REG_ADDR == `CEDU_A_EPC) begin
      exception_return_pc <= REG_WDATA;
    end
  end

  // software requests: written 1 sets, 0 clears
  always_ff @(posedge SYS_CLK or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sw_ip <= 2'h0;
    end else if (wr_cause) begin
      sw_ip <= REG_WDATA[`CEDU_CA_SW];
    end
  end

  // ========================================================
  // watch address registers
  always_ff @(posedge SYS_CLK or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wlo <= 32'h0000_0000;
      whi <= 32'h0000_0000;
    end else begin
      if (wr_wlo) begin
        wlo <= REG_WDATA;
      end
      if (REG_WR && REG_ADDR == `CEDU_A_WHI) begin
        whi <= {24'h00_0000, REG_WDATA[`CEDU_WH_ADDR]};
      end
    end
  end

  // ========================================================
  // timer: count runs every cycle it is not written, flag sticky
  always_ff @(posedge SYS_CLK or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      count      <= 32'h0000_0000;
      compare    <= 32'h0000_0000;
      timer_flag <= 1'b0;
    end else begin
      if (REG_WR && REG_ADDR == `CEDU_A_COUNT) begin
        count <= REG_WDATA;
      end else begin
        count <= count + 32'h0000_0001;
      end
      if (wr_cmp) begin
        compare <= REG_WDATA;
      end
      // a match in the write cycle still sets the flag
      if (count == compare) begin
        timer_flag <= 1'b1;
      end else if (wr_cmp) begin
        timer_flag <= 1'b0;
      end
    end
  end

  // ========================================================
  // performance counters; bit 31 is the overflow flag
  logic [31:0] perf0_base;
  logic [31:0] perf1_base;

  assign perf0_base = (REG_WR && REG_ADDR == `CEDU_A_PERF0) ?
                      REG_WDATA : perf0;
  assign perf1_base = (REG_WR && REG_ADDR == `CEDU_A_PERF1) ?
                      REG_WDATA : perf1;

  // events add on top of a write so none is lost
  always_ff @(posedge SYS_CLK or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      perf0 <= 32'h0000_0000;
      perf1 <= 32'h0000_0000;
    end else begin
      perf0 <= perf0_base + {31'h0, PERF_EVENT[0]};
      perf1 <= perf1_base + {31'h0, PERF_EVENT[1]};
    end
  end

  // ========================================================
  // exception record and cache effect to the pipeline
  always_ff @(posedge SYS_CLK or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      EXC        <= '0;
      CACHE_KEEP <= 1'b0;
      FILL_GO    <= 1'b0;
    end else begin
      EXC.take <= take;
      EXC.code <= code;
      EXC.pc   <= epc_src;
      EXC.bd   <= INSTR.delay_slot;
      EXC.ce   <= cop_unit;
      // only a cacheable miss may still move a line
      CACHE_KEEP <= watch_now &
                    !(INSTR.cacheable & INSTR.dc_miss);
      FILL_GO    <= watch_now & INSTR.cacheable &
                    INSTR.dc_miss;
    end
  end

  // ========================================================
  // register read, data in the cycle after the strobe
  always_ff @(posedge SYS_CLK or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      REG_RDATA <= 32'h0000_0000;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `CEDU_A_STATUS:  REG_RDATA <= status;
        `CEDU_A_CAUSE: begin
          REG_RDATA <= 32'h0000_0000;
          REG_RDATA[`CEDU_CA_BD]  <= bd;
          REG_RDATA[`CEDU_CA_CE]  <= ce;
          REG_RDATA[`CEDU_CA_IP]  <= ip;
          REG_RDATA[`CEDU_CA_EXC] <= exc_code;
        end
        `CEDU_A_EPC:     REG_RDATA <= exception_return_pc;
        `CEDU_A_WLO:     REG_RDATA <= wlo;
        `CEDU_A_WHI:     REG_RDATA <= whi;
        `CEDU_A_COUNT:   REG_RDATA <= count;
        `CEDU_A_COMPARE: REG_RDATA <= compare;
        `CEDU_A_PERF0:   REG_RDATA <= perf0;
        `CEDU_A_PERF1:   REG_RDATA <= perf1;
        default:         REG_RDATA <= 32'h0000_0000;
      endcase
    end
  end

  // ========================================================
  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!rst_sync_b);

  a_major_reserved: assert property (
    INSTR.valid && ri_major |=>
      EXC.take && EXC.code == `CEDU_EXC_RI)
    else $error("undefined major opcode not reserved");

  a_special_reserved: assert property (
    INSTR.valid && ri_spec |=> EXC.code == `CEDU_EXC_RI)
    else $error("undefined function code not reserved");

  a_reg_immediate_group_reserved: assert property (
    INSTR.valid && ri_rimm |=> EXC.code == `CEDU_EXC_RI)
    else $error("undefined sub-opcode not reserved");

  a_user_wide_op: assert property (
    INSTR.valid && INSTR.op64 && !lvl &&
    status[`CEDU_ST_KSU] == `CEDU_KSU_USER &&
    !status[`CEDU_ST_UX] |=>
      EXC.take && EXC.code == `CEDU_EXC_RI)
    else $error("64-bit op in user 32-bit mode passed");

  a_kernel_wide_op: assert property (
    INSTR.valid && INSTR.op64 && kern && !ri_major &&
    !ri_spec && !ri_rimm && !ri_fx |=>
      !(EXC.take && EXC.code == `CEDU_EXC_RI))
    else $error("64-bit op in kernel mode reserved");

  a_indexed_fp: assert property (
    INSTR.valid && ri_fx |=> EXC.code == `CEDU_EXC_RI)
    else $error("indexed float op passed while disabled");

  a_epc_slot: assert property (
    take && !status[`CEDU_ST_EXL] |=>
      exception_return_pc == $past(epc_src) && bd == $past(INSTR.delay_slot))
    else $error("epc or slot flag wrong after entry");

  a_cop_unit: assert property (
    cpu_hit && !ri_hit |=> EXC.code == `CEDU_EXC_CPU &&
      ce == $past(cop_unit))
    else $error("coprocessor fault not recorded");

  a_float_fault: assert property (
    fpe_hit && !ri_hit && !cpu_hit |=>
      EXC.take && EXC.code == `CEDU_EXC_FPE)
    else $error("float fault not taken");

  a_watch_defer: assert property (
    defer_set |=> wstate == CEDU_W_PEND &&
      (!EXC.take || EXC.code != `CEDU_EXC_WATCH))
    else $error("deferred watch not held");

  a_watch_drop: assert property (
    wr_wlo && !defer_set |=> wstate == CEDU_W_IDLE)
    else $error("watch-low write kept pending watch");

  a_cache_no_watch: assert property (
    INSTR.valid && INSTR.is_cache && !wr_wlo &&
    wstate == CEDU_W_IDLE |=> wstate == CEDU_W_IDLE &&
      !CACHE_KEEP && !FILL_GO)
    else $error("cache op raised watch");

  a_timer_bit: assert property (
    count == compare |=> ip[`CEDU_IP_TIMER] ##1
      (ip[`CEDU_IP_TIMER] || $past(wr_cmp)))
    else $error("timer match did not raise bit 7");

  a_irq_gate: assert property (
    !status[`CEDU_ST_IE] |-> !int_hit)
    else $error("interrupt taken with global enable off");

  c_reserved: cover property (
    INSTR.valid && ri_hit ##1 EXC.take);
  c_watch_later: cover property (
    defer_set ##[1:20] pend_go);
  c_interrupt: cover property (
    int_hit && !ri_hit ##1 EXC.code == `CEDU_EXC_INT);
  c_fill: cover property (FILL_GO);

endmodule

`default_nettype wire
